// file: dv/ssc_peer.sv
/*
  Far-side serial peer: an SPI slave answering the port's master, and a
  two-wire controller that sends start, bytes and stop.
  Assumes the testbench selects the role through spi_i.
*/
`timescale 1ns/10ps
module ssc_peer (
  input wire logic sck_i,
  input wire logic sdo_i,
  input wire logic sda_oe_n_i,
  input wire logic spi_i,
  input wire logic cke_i,
  input wire logic ckp_i,
  output logic scl_o,
  output logic sdi_o
);
  logic [7:0] reply = 8'h00;
  logic [7:0] got = 8'h00;
  logic sdi_spi = 1'h1;
  logic sda = 1'h1;
  logic first = 1'h0;
  int k = 7;

  initial scl_o = 1'h1;

  // data line: slave data, else wired-and with pull-up
  assign sdi_o = spi_i ? sdi_spi : (sda & sda_oe_n_i);

  // load the answer byte, msb shown before the first edge
  task automatic arm(input logic [7:0] r);
    reply = r;
    k = 7;
    first = 1'h1;
    sdi_spi = r[7];
    got = 8'h00;
  endtask

  // launch on one edge, sample on the other; after sampling the hold time
  // is over and the line flips, so late capture sees the wrong level
  always @(posedge sck_i or negedge sck_i) begin
    if (spi_i) begin
      if (sck_i == (cke_i ^ ckp_i)) begin
        if (!(first && cke_i)) k = k - 1;
        first = 1'h0;
        if (k >= 0) sdi_spi = reply[k];
      end else begin
        got = {got[6:0], sdo_i};
        sdi_spi = ~sdi_spi;
      end
    end
  end

  // one two-wire bit, clock period 200 ns
  task automatic tw_bit(input logic b);
    scl_o = 1'h0;
    #50 sda = b;
    #50 scl_o = 1'h1;
    #100;
  endtask

  // eight bits then the acknowledge clock with the line released
  task automatic tw_byte(input logic [7:0] v);
    for (int i = 7; i >= 0; i--) tw_bit(v[i]);
    tw_bit(1'h1);
    scl_o = 1'h0;
  endtask

  // start when b is 0, stop when b is 1: data moves while clock high
  task automatic tw_cond(input logic b);
    scl_o = 1'h0;
    #50 sda = !b;
    #50 scl_o = 1'h1;
    #100 sda = b;
    #100;
  endtask
endmodule

// file: dv/tb_ssc_serial_port.sv
/*
  Self-checking testbench of the serial port: APB register access, SPI master
  transfers in all edge and phase settings, two-wire byte reception.
  Assumes ssc_peer on the serial pins and a zero-wait APB slave.
*/
`timescale 1ns/10ps
module tb_ssc_serial_port;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, irq, sck_o, sck_oe_n, sdo, sda_oe_n, scl, sdi;
  logic spi = 1'h1;
  logic ss_n = 1'h1;
  logic input_sample_phase, cke, clock_idle_polarity;
  logic [7:0] tx, rp;
  int error_cnt = 0;
  int total_checks = 0;

  always #12.5 clk = ~clk;

  ssc_serial_port u_dut (.CLK_SYS_I(clk), .RESET_I(rst), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .IRQ_O(irq), .SCK_I(scl), .SCK_O(sck_o), .SCK_OE_N_O(sck_oe_n),
    .SDI_I(sdi), .SDO_O(sdo), .SS_N_I(ss_n), .SDA_O(), .SDA_OE_N_O(sda_oe_n));

  ssc_peer u_peer (.sck_i(sck_o), .sdo_i(sdo), .sda_oe_n_i(sda_oe_n), .spi_i(spi), .cke_i(cke),
    .ckp_i(clock_idle_polarity), .scl_o(scl), .sdi_o(sdi));

  // ----------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------
  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one APB transfer: setup, access held until pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  // masked read compare of a byte-wide register
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] msk);
    apb(1'h0, a, 32'h0);
    chk(rd & {24'h0, msk}, {24'h0, exp});
  endtask

  // verdict and end of run
  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // watchdog far beyond the expected run of about 30 us
  initial begin
    #400000;
    error_cnt++;
    conclude();
  end

  // ----------------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------------
  initial begin
    {input_sample_phase, cke, clock_idle_polarity} = 3'h0;
    repeat (5) @(posedge clk);
    rst <= 1'h0;
    rdc(ssc_pkg::ADDR_STATUS, ssc_pkg::STATUS_RST, 8'hFF);
    apb(1'h1, ssc_pkg::ADDR_STATUS, 32'hFF);
    rdc(ssc_pkg::ADDR_STATUS, 8'hC0, 8'hFF);
    apb(1'h0, 8'h00, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    apb(1'h1, ssc_pkg::ADDR_IRQ_EN, 32'h1);
    // every combination of sample phase, edge select and idle polarity
    for (int m = 0; m < 8; m++) begin
      {clock_idle_polarity, cke, input_sample_phase} = 3'(m);
      tx = 8'hA5 ^ 8'(m);
      rp = 8'h3C + 8'(m);
      apb(1'h1, ssc_pkg::ADDR_CTRL, {16'h0, 8'h04, 4'h0, clock_idle_polarity, 3'h1});
      apb(1'h1, ssc_pkg::ADDR_STATUS, {24'h0, input_sample_phase, cke, 6'h0});
      u_peer.arm(rp);
      rdc(ssc_pkg::ADDR_STATUS, {input_sample_phase, cke, 6'h0}, 8'hFF);
      apb(1'h1, ssc_pkg::ADDR_DATA, {24'h0, tx});
      for (int i = 0; i < 300 && irq !== 1'h1; i++) @(posedge clk);
      chk({31'h0, irq}, 32'h1);
      chk({24'h0, u_peer.got}, {24'h0, tx});
      chk({30'h0, sck_o, sck_oe_n}, {30'h0, clock_idle_polarity, 1'h0});
      rdc(ssc_pkg::ADDR_STATUS, {input_sample_phase, cke, 6'h01}, 8'hFF);
      rdc(ssc_pkg::ADDR_DATA, input_sample_phase ? ~rp : rp, 8'hFF);
      rdc(ssc_pkg::ADDR_STATUS, {input_sample_phase, cke, 6'h00}, 8'hFF);
      apb(1'h1, ssc_pkg::ADDR_IRQ_EN, 32'h0);
      @(posedge clk);
      chk({31'h0, irq}, 32'h0);
      rdc(ssc_pkg::ADDR_IRQ_STAT, 8'h01, 8'hFF);
      apb(1'h1, ssc_pkg::ADDR_IRQ_CLR, 32'h1);
      apb(1'h1, ssc_pkg::ADDR_IRQ_EN, 32'h1);
      rdc(ssc_pkg::ADDR_IRQ_STAT, 8'h00, 8'hFF);
    end
    // spi slave: eight clocks from the peer with select low, data line high
    {input_sample_phase, cke, clock_idle_polarity} = 3'h0;
    apb(1'h1, ssc_pkg::ADDR_STATUS, 32'h0);
    apb(1'h1, ssc_pkg::ADDR_CTRL, {16'h0, 8'h04, 8'h03});
    u_peer.arm(8'hFF);
    ss_n <= 1'h0;
    for (int i = 0; i < 8; i++) u_peer.tw_bit(1'h0);
    repeat (4) @(posedge clk);
    rdc(ssc_pkg::ADDR_STATUS, 8'h01, 8'hFF);
    rdc(ssc_pkg::ADDR_DATA, 8'hFF, 8'hFF);
    ss_n <= 1'h1;
    // two-wire: address byte, data byte, stop
    spi = 1'h0;
    {input_sample_phase, cke} = 2'h0;
    apb(1'h1, ssc_pkg::ADDR_STATUS, 32'h0);
    apb(1'h1, ssc_pkg::ADDR_CTRL, {16'h0, 8'h04, 8'h05});
    u_peer.tw_cond(1'h0);
    u_peer.tw_byte(8'hA1);
    rdc(ssc_pkg::ADDR_STATUS, 8'h0D, 8'hFF);
    rdc(ssc_pkg::ADDR_DATA, 8'hA1, 8'hFF);
    u_peer.tw_byte(8'h5A);
    rdc(ssc_pkg::ADDR_STATUS, 8'h29, 8'hFB);
    rdc(ssc_pkg::ADDR_DATA, 8'h5A, 8'hFF);
    u_peer.tw_cond(1'h1);
    rdc(ssc_pkg::ADDR_STATUS, 8'h30, 8'hFB);
    rdc(ssc_pkg::ADDR_IRQ_STAT, 8'h07, 8'hFF);
    conclude();
  end
endmodule

// file: hdl/ssc_link_if.sv
/*
  Synchronised serial pin levels and edge pulses passed from the pin front end
  to the port core. All signals are on the system clock.
*/
`timescale 1ns/10ps
interface ssc_link_if;
  logic sck;
  logic sdi;
  logic ss_n;
  logic sck_rise;
  logic sck_fall;
  logic sdi_rise;
  logic sdi_fall;
  logic ss_fall;

  modport front (output sck, sdi, ss_n, sck_rise, sck_fall, sdi_rise, sdi_fall, ss_fall);
  modport core (input sck, sdi, ss_n, sck_rise, sck_fall, sdi_rise, sdi_fall, ss_fall);
endinterface

// file: hdl/ssc_pin_sync.sv
/*
  Two-flop synchronisers for the serial pins plus edge detection.
  Assumes pins are asynchronous to the system clock.
*/
`timescale 1ns/10ps
module ssc_pin_sync (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic sck_i,
  input wire logic sdi_i,
  input wire logic ss_n_i,
  ssc_link_if.front lk
);

  // ----------------------------------------------------------------------
  // synchroniser stages: meta, stable, previous stable
  // ----------------------------------------------------------------------
  logic [2:0] meta;
  logic [2:0] stab;
  logic [2:0] prev;
  logic [2:0] next_meta;
  logic [2:0] next_stab;
  logic [2:0] next_prev;

  // next values: meta feeds only stab
  always_comb begin
    next_meta = {ss_n_i, sdi_i, sck_i};
    next_stab = meta;
    next_prev = stab;
  end

  // register stages, all lines idle high so no false edge follows reset
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      meta <= 3'h7;
      stab <= 3'h7;
      prev <= 3'h7;
    end else begin
      meta <= next_meta;
      stab <= next_stab;
      prev <= next_prev;
    end
  end

  // levels and edges from stable stages only
  assign lk.sck = stab[0];
  assign lk.sdi = stab[1];
  assign lk.ss_n = stab[2];
  assign lk.sck_rise = stab[0] & ~prev[0];
  assign lk.sck_fall = ~stab[0] & prev[0];
  assign lk.sdi_rise = stab[1] & ~prev[1];
  assign lk.sdi_fall = ~stab[1] & prev[1];
  assign lk.ss_fall = ~stab[2] & prev[2];

endmodule

// file: hdl/ssc_pkg.sv
/*
  Constants, register map and mode enumeration of the synchronous serial port.
  Assumes a 40 MHz system clock and an APB slave with 32-bit data.
*/
package ssc_pkg;

  // ----------------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_STATUS = 8'h94;
  localparam logic [7:0] ADDR_CTRL = 8'h98;
  localparam logic [7:0] ADDR_DATA = 8'h9C;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'hA0;
  localparam logic [7:0] ADDR_IRQ_CLR = 8'hA4;
  localparam logic [7:0] ADDR_IRQ_EN = 8'hA8;

  // ----------------------------------------------------------------------
  // serial_port_status fields
  // ----------------------------------------------------------------------
  localparam int STAT_SMP = 7;
  localparam int STAT_CKE = 6;
  localparam int STAT_DA = 5;
  localparam int STAT_STOP = 4;
  localparam int STAT_START = 3;
  localparam int STAT_RW = 2;
  localparam int STAT_UA = 1;
  localparam int STAT_BF = 0;
  localparam logic [7:0] STATUS_RST = 8'h00;

  // ----------------------------------------------------------------------
  // control fields
  // ----------------------------------------------------------------------
  localparam int CTRL_EN = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam int CTRL_CKP = 3;
  localparam int CTRL_DIV_LSB = 8;

  // ----------------------------------------------------------------------
  // interrupt fields
  // ----------------------------------------------------------------------
  localparam int IRQ_W = 3;
  localparam int IRQ_BYTE = 0;
  localparam int IRQ_START = 1;
  localparam int IRQ_STOP = 2;
  localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int CLK_NS = 25;
  localparam int SCK_HALF_NS = 100;
  localparam logic [7:0] SCK_HALF_CYC = 8'((SCK_HALF_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [15:0] CTRL_RST = {SCK_HALF_CYC, 8'h00};
  localparam logic [4:0] LAST_PHASE = 5'h10;
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [3:0] ACK_BIT = 4'h8;

  // ----------------------------------------------------------------------
  // operating modes
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    SSC_SPI_MASTER,
    SSC_SPI_SLAVE,
    SSC_I2C,
    SSC_MODE_RSVD
  } ssc_mode_e;

  typedef enum logic {
    SSC_M_IDLE,
    SSC_M_RUN
  } ssc_mst_e;

endpackage

// file: hdl/ssc_serial_port.sv
/*
  Synchronous serial port: SPI master or slave, or two-wire byte receiver,
  with its status register, control, data and interrupt registers on APB.
  Assumes APB master on CLK_SYS_I and serial pins asynchronous to it.
*/
// How it works
// - master, sample bit set: capture at bit end
// - master, sample bit clear: capture mid bit
// - idle-low clock: edge bit picks launch edge
// - idle-high clock: edge bit picks launch edge
// - two-wire: flag data byte versus address byte
// - two-wire: start flag set on start condition
// - buffer full set when received byte completes
`timescale 1ns/10ps
module ssc_serial_port (
  input wire logic CLK_SYS_I,
  input wire logic RESET_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  output logic IRQ_O,
  input wire logic SCK_I,
  output logic SCK_O,
  output logic SCK_OE_N_O,
  input wire logic SDI_I,
  output logic SDO_O,
  input wire logic SS_N_I,
  output logic SDA_O,
  output logic SDA_OE_N_O
);

  ssc_link_if lk ();

  // ----------------------------------------------------------------------
  // pin front end
  // ----------------------------------------------------------------------
  ssc_pin_sync u_sync (
    .clk_i(CLK_SYS_I),
    .reset_i(RESET_I),
    .sck_i(SCK_I),
    .sdi_i(SDI_I),
    .ss_n_i(SS_N_I),
    .lk(lk.front)
  );

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  logic [15:0] ctrl, next_ctrl;
  logic input_sample_phase, next_smp;
  logic cke, next_cke;
  logic bf, next_bf;
  logic [7:0] rx_buf, next_rx_buf;
  logic [ssc_pkg::IRQ_W-1:0] irq_stat, next_irq_stat;
  logic [ssc_pkg::IRQ_W-1:0] irq_en, next_irq_en;
  logic [31:0] prdata, next_prdata;
  ssc_pkg::ssc_mst_e mst, next_mst;
  logic [4:0] phase, next_phase;
  logic [7:0] div_cnt, next_div_cnt;
  logic sck_out, next_sck_out;
  logic sdo, next_sdo;
  logic [7:0] tx_shift, next_tx_shift;
  logic [7:0] rx_shift, next_rx_shift;
  logic [3:0] bit_cnt, next_bit_cnt;
  logic i2c_first, next_i2c_first;
  logic sda_oe_n, next_sda_oe_n;
  logic da, next_da;
  logic rw, next_rw;
  logic start_seen, next_start_seen;
  logic stop_seen, next_stop_seen;
  logic ev_byte, ev_start, ev_stop;
  logic cap_pulse, launch_edge, tick;
  logic access, wr_acc, rd_data_acc, wr_data_go, mapped;
  logic en, clock_idle_polarity;
  logic [7:0] div_lim;
  ssc_pkg::ssc_mode_e mode;

  assign en = ctrl[ssc_pkg::CTRL_EN];
  assign clock_idle_polarity = ctrl[ssc_pkg::CTRL_CKP];
  assign mode = ssc_pkg::ssc_mode_e'(ctrl[ssc_pkg::CTRL_MODE_LSB +: 2]);
  assign div_lim = (ctrl[ssc_pkg::CTRL_DIV_LSB +: 8] == 8'h00) ? 8'h00 : ctrl[ssc_pkg::CTRL_DIV_LSB +: 8] - 8'h01;

  // ----------------------------------------------------------------------
  // apb decode, zero wait states
  // ----------------------------------------------------------------------
  assign access = PSEL_I & PENABLE_I;
  assign wr_acc = access & PWRITE_I;
  assign rd_data_acc = access & ~PWRITE_I & (PADDR_I == ssc_pkg::ADDR_DATA);
  assign wr_data_go = wr_acc & (PADDR_I == ssc_pkg::ADDR_DATA);
  assign mapped = (PADDR_I == ssc_pkg::ADDR_STATUS) | (PADDR_I == ssc_pkg::ADDR_CTRL) |
                  (PADDR_I == ssc_pkg::ADDR_DATA) | (PADDR_I == ssc_pkg::ADDR_IRQ_STAT) |
                  (PADDR_I == ssc_pkg::ADDR_IRQ_CLR) | (PADDR_I == ssc_pkg::ADDR_IRQ_EN);
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = access & ~mapped;
  assign PRDATA_O = prdata;
  assign IRQ_O = |(irq_stat & irq_en);

  // ----------------------------------------------------------------------
  // shift engine: next values for all three modes
  // ----------------------------------------------------------------------
  always_comb begin
    next_mst = mst;
    next_phase = phase;
    next_div_cnt = div_cnt;
    next_sck_out = sck_out;
    next_sdo = sdo;
    next_tx_shift = tx_shift;
    next_rx_shift = rx_shift;
    next_bit_cnt = bit_cnt;
    next_i2c_first = i2c_first;
    next_sda_oe_n = sda_oe_n;
    next_da = da;
    next_rw = rw;
    next_start_seen = start_seen;
    next_stop_seen = stop_seen;
    ev_byte = 1'b0;
    ev_start = 1'b0;
    ev_stop = 1'b0;
    cap_pulse = 1'b0;
    launch_edge = 1'b0;
    tick = 1'b0;
    if (!en) begin
      next_mst = ssc_pkg::SSC_M_IDLE;
      next_sck_out = clock_idle_polarity;
      next_bit_cnt = 4'h0;
      next_sda_oe_n = 1'b1;
      next_start_seen = 1'b0;
      next_stop_seen = 1'b0;
      if (wr_data_go) begin
        next_tx_shift = PWDATA_I[7:0];
      end
    end else begin
      unique case (mode)
        ssc_pkg::SSC_SPI_MASTER: begin
          unique case (mst)
            ssc_pkg::SSC_M_IDLE: begin
              next_sck_out = clock_idle_polarity;
              if (wr_data_go) begin
                next_mst = ssc_pkg::SSC_M_RUN;
                next_div_cnt = 8'h00;
                next_tx_shift = PWDATA_I[7:0];
                next_phase = cke ? 5'h00 : 5'h01;
                // edge bit clear: first bit stands before the first edge
                if (!cke) begin
                  next_sdo = PWDATA_I[7];
                  next_tx_shift = {PWDATA_I[6:0], 1'b0};
                end
              end
            end
            ssc_pkg::SSC_M_RUN: begin
              next_div_cnt = div_cnt + 8'h01;
              tick = (div_cnt >= div_lim);
              if (tick) begin
                next_div_cnt = 8'h00;
                // no clock edge on the closing half period with edge bit set
                if (!(phase == ssc_pkg::LAST_PHASE && cke)) begin
                  next_sck_out = ~sck_out;
                end
                if (!phase[0]) begin
                  if (input_sample_phase && phase != 5'h00) begin
                    cap_pulse = 1'b1;
                  end
                  if (phase != ssc_pkg::LAST_PHASE) begin
                    launch_edge = !(phase == 5'h00 && !cke);
                    next_sdo = tx_shift[7];
                    next_tx_shift = {tx_shift[6:0], 1'b0};
                  end
                end else if (!input_sample_phase) begin
                  cap_pulse = 1'b1;
                end
                if (cap_pulse) begin
                  next_rx_shift = {rx_shift[6:0], lk.sdi};
                end
                if (phase == ssc_pkg::LAST_PHASE) begin
                  next_mst = ssc_pkg::SSC_M_IDLE;
                  ev_byte = 1'b1;
                end else begin
                  next_phase = phase + 5'h01;
                end
              end
            end
          endcase
        end
        ssc_pkg::SSC_SPI_SLAVE: begin
          next_mst = ssc_pkg::SSC_M_IDLE;
          if (lk.ss_n) begin
            next_bit_cnt = 4'h0;
            if (wr_data_go) begin
              next_tx_shift = PWDATA_I[7:0];
            end
          end else begin
            if (lk.ss_fall && !cke) begin
              next_sdo = tx_shift[7];
              next_tx_shift = {tx_shift[6:0], 1'b0};
            end
            // launch on rising edge when edge bit differs from idle level
            if ((cke ^ clock_idle_polarity) ? lk.sck_rise : lk.sck_fall) begin
              next_sdo = tx_shift[7];
              next_tx_shift = {tx_shift[6:0], 1'b0};
            end
            // capture on the opposite edge, mid bit, whatever the sample bit holds
            if ((cke ^ clock_idle_polarity) ? lk.sck_fall : lk.sck_rise) begin
              cap_pulse = 1'b1;
              next_rx_shift = {rx_shift[6:0], lk.sdi};
              next_bit_cnt = bit_cnt + 4'h1;
              if (bit_cnt == ssc_pkg::LAST_BIT) begin
                next_bit_cnt = 4'h0;
                ev_byte = 1'b1;
              end
            end
          end
        end
        ssc_pkg::SSC_I2C: begin
          next_mst = ssc_pkg::SSC_M_IDLE;
          // data line moves while clock line is high: bus condition
          if (lk.sdi_fall && lk.sck) begin
            ev_start = 1'b1;
            next_start_seen = 1'b1;
            next_stop_seen = 1'b0;
            // the clock fall that follows a start ends no bit: wraps to zero
            next_bit_cnt = 4'hF;
            next_i2c_first = 1'b1;
            next_sda_oe_n = 1'b1;
          end else if (lk.sdi_rise && lk.sck) begin
            ev_stop = 1'b1;
            next_stop_seen = 1'b1;
            next_start_seen = 1'b0;
            next_bit_cnt = 4'h0;
            next_sda_oe_n = 1'b1;
          end else if (lk.sck_rise && bit_cnt < ssc_pkg::ACK_BIT) begin
            cap_pulse = 1'b1;
            next_rx_shift = {rx_shift[6:0], lk.sdi};
          end else if (lk.sck_fall) begin
            next_bit_cnt = bit_cnt + 4'h1;
            if (bit_cnt == ssc_pkg::LAST_BIT) begin
              ev_byte = 1'b1;
              next_da = !i2c_first;
              next_i2c_first = 1'b0;
              if (i2c_first) begin
                next_rw = rx_shift[0];
              end
              next_sda_oe_n = 1'b0; // acknowledge every byte
            end else if (bit_cnt == ssc_pkg::ACK_BIT) begin
              next_bit_cnt = 4'h0;
              next_sda_oe_n = 1'b1;
            end
          end
        end
        ssc_pkg::SSC_MODE_RSVD: begin
          next_mst = ssc_pkg::SSC_M_IDLE;
          next_sda_oe_n = 1'b1;
        end
      endcase
    end
  end

  // engine registers
  always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
    if (RESET_I) begin
      mst <= ssc_pkg::SSC_M_IDLE;
      phase <= 5'h00;
      div_cnt <= 8'h00;
      sck_out <= 1'b0;
      sdo <= 1'b0;
      tx_shift <= 8'h00;
      rx_shift <= 8'h00;
      bit_cnt <= 4'h0;
      i2c_first <= 1'b1;
      sda_oe_n <= 1'b1;
      da <= 1'b0;
      rw <= 1'b0;
      start_seen <= 1'b0;
      stop_seen <= 1'b0;
    end else begin
      mst <= next_mst;
      phase <= next_phase;
      div_cnt <= next_div_cnt;
      sck_out <= next_sck_out;
      sdo <= next_sdo;
      tx_shift <= next_tx_shift;
      rx_shift <= next_rx_shift;
      bit_cnt <= next_bit_cnt;
      i2c_first <= next_i2c_first;
      sda_oe_n <= next_sda_oe_n;
      da <= next_da;
      rw <= next_rw;
      start_seen <= next_start_seen;
      stop_seen <= next_stop_seen;
    end
  end

  assign SCK_O = sck_out;
  assign SCK_OE_N_O = ~(en & (mode == ssc_pkg::SSC_SPI_MASTER));
  assign SDO_O = sdo;
  assign SDA_O = 1'b0;
  assign SDA_OE_N_O = sda_oe_n;

  // ----------------------------------------------------------------------
  // register file: writes, read data, sticky flags
  // ----------------------------------------------------------------------
  always_comb begin
    next_ctrl = ctrl;
    next_smp = input_sample_phase;
    next_cke = cke;
    next_irq_en = irq_en;
    next_rx_buf = rx_buf;
    next_bf = bf;
    next_prdata = prdata;
    next_irq_stat = irq_stat;
    if (wr_acc) begin
      unique case (PADDR_I)
        ssc_pkg::ADDR_STATUS: begin
          next_smp = PWDATA_I[ssc_pkg::STAT_SMP];
          next_cke = PWDATA_I[ssc_pkg::STAT_CKE];
        end
        ssc_pkg::ADDR_CTRL: next_ctrl = PWDATA_I[15:0];
        ssc_pkg::ADDR_IRQ_CLR: next_irq_stat = irq_stat & ~PWDATA_I[ssc_pkg::IRQ_W-1:0];
        ssc_pkg::ADDR_IRQ_EN: next_irq_en = PWDATA_I[ssc_pkg::IRQ_W-1:0];
        default: next_ctrl = ctrl;
      endcase
    end
    // events win over a clear in the same cycle
    next_irq_stat = next_irq_stat | {ev_stop, ev_start, ev_byte};
    if (rd_data_acc) begin
      next_bf = 1'b0;
    end
    if (ev_byte) begin
      next_bf = 1'b1;
      next_rx_buf = next_rx_shift;
    end
    // read data prepared in the setup phase
    if (PSEL_I && !PENABLE_I) begin
      next_prdata = 32'h0000_0000;
      unique case (PADDR_I)
        ssc_pkg::ADDR_STATUS: next_prdata[7:0] = {input_sample_phase, cke, da, stop_seen, start_seen, rw, 1'b0, bf};
        ssc_pkg::ADDR_CTRL: next_prdata[15:0] = ctrl;
        ssc_pkg::ADDR_DATA: next_prdata[7:0] = rx_buf;
        ssc_pkg::ADDR_IRQ_STAT: next_prdata[ssc_pkg::IRQ_W-1:0] = irq_stat;
        ssc_pkg::ADDR_IRQ_EN: next_prdata[ssc_pkg::IRQ_W-1:0] = irq_en;
        default: next_prdata = 32'h0000_0000;
      endcase
    end
  end

  // register file flops
  always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
    if (RESET_I) begin
      ctrl <= ssc_pkg::CTRL_RST;
      input_sample_phase <= ssc_pkg::STATUS_RST[ssc_pkg::STAT_SMP];
      cke <= ssc_pkg::STATUS_RST[ssc_pkg::STAT_CKE];
      bf <= ssc_pkg::STATUS_RST[ssc_pkg::STAT_BF];
      rx_buf <= 8'h00;
      irq_stat <= ssc_pkg::IRQ_RST;
      irq_en <= ssc_pkg::IRQ_RST;
      prdata <= 32'h0000_0000;
    end else begin
      ctrl <= next_ctrl;
      input_sample_phase <= next_smp;
      cke <= next_cke;
      bf <= next_bf;
      rx_buf <= next_rx_buf;
      irq_stat <= next_irq_stat;
      irq_en <= next_irq_en;
      prdata <= next_prdata;
    end
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (RESET_I);

  chk_end_sample_phase: assert property (
    (cap_pulse && mode == ssc_pkg::SSC_SPI_MASTER && input_sample_phase) |-> (!phase[0] && phase != 5'h00))
    else $error("end-of-bit capture at wrong phase");
  chk_mid_sample_phase: assert property (
    (cap_pulse && mode == ssc_pkg::SSC_SPI_MASTER && !input_sample_phase) |-> phase[0])
    else $error("mid-bit capture at wrong phase");
  chk_launch_idle_low: assert property (
    (launch_edge && !clock_idle_polarity) |=> (SCK_O == cke && $changed(SCK_O)))
    else $error("launch edge wrong with idle-low clock");
  chk_launch_idle_high: assert property (
    (launch_edge && clock_idle_polarity) |=> (SCK_O == !cke && $changed(SCK_O)))
    else $error("launch edge wrong with idle-high clock");
  chk_addr_byte_flag: assert property (
    (ev_byte && mode == ssc_pkg::SSC_I2C && i2c_first) |=> (!da && !i2c_first))
    else $error("address byte not flagged");
  chk_data_byte_flag: assert property (
    (ev_byte && mode == ssc_pkg::SSC_I2C && !i2c_first) |=> da)
    else $error("data byte not flagged");
  chk_start_flag_set: assert property (
    (ev_start && en) |=> (start_seen && !stop_seen) ##1 (start_seen || ev_stop || !en))
    else $error("start flag not set after start condition");
  chk_full_on_byte: assert property (
    ev_byte |=> (bf && rx_buf == $past(next_rx_shift)))
    else $error("buffer full not set on completed byte");
  chk_full_clear_read: assert property (
    (rd_data_acc && !ev_byte) |=> !bf)
    else $error("buffer full not cleared by data read");

endmodule
